// ---- tocu_top.sv ----
// Purpose: Output compare, counter and waveform output of a 16-bit timer
// Assumes: tick is the one-cycle timer clock enable from the prescaler
// Notes: Register port data are 8 bits; reads answer one cycle later
`default_nettype none
module tocu_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [15:0] capture_value,
  input wire logic [2:0] irq_serviced,
  output logic [2:0] irq_request,
  input wire logic [1:0] port_value,
  input wire logic [1:0] output_pin_direction,
  output logic [1:0] compare_output,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [15:0] timer_count,
  output logic overflow_flag,
  output logic [1:0] compare_match_flag
);
  import tocu_pkg::*;

  tocu_state_t r;
  tocu_state_t next_r;

  // ****************************************************
  // Mode decode
  // ****************************************************
  logic pwm;
  logic dual;
  logic load_at_bottom;
  logic ovf_at_max;
  logic [15:0] top;
  logic top_var;

  always_comb begin
    pwm = 1'b1;
    dual = 1'b0;
    load_at_bottom = 1'b0;
    ovf_at_max = 1'b0;
    top = CNT_MAX;
    // Only tops held in registers obey match blocking
    top_var = 1'b0;
    case (r.mode)
      4'h0: begin
        pwm = 1'b0;
      end
      4'h1, 4'h5: begin
        top = TOP_8BIT;
      end
      4'h2, 4'h6: begin
        top = TOP_9BIT;
      end
      4'h3, 4'h7: begin
        top = TOP_10BIT;
      end
      4'h4: begin
        top_var = 1'b1;
        pwm = 1'b0;
        ovf_at_max = 1'b1;
        top = r.active[0];
      end
      4'h8, 4'hA: begin
        top_var = 1'b1;
        top = capture_value;
      end
      4'h9, 4'hB, 4'hF: begin
        top_var = 1'b1;
        top = r.active[0];
      end
      4'hC: begin
        top_var = 1'b1;
        pwm = 1'b0;
        ovf_at_max = 1'b1;
        top = capture_value;
      end
      4'hE: begin
        top_var = 1'b1;
        top = capture_value;
      end
      default: begin
        pwm = 1'b0;
      end
    endcase
    dual = pwm && (r.mode inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA,
                                  4'hB});
    load_at_bottom = r.mode inside {4'h8, 4'h9};
  end

  // ****************************************************
  // Next state
  // ****************************************************
  logic [1:0] match;
  logic [1:0] force_hit;
  logic at_top;
  logic at_bottom;
  logic wrap;
  logic [1:0] act;
  logic [15:0] wide;
  logic top_hit;
  logic ovf_set;

  always_comb begin
    next_r = r;
    match = 2'b00;
    force_hit = 2'b00;
    act = ACT_NONE;
    wide = CNT_ZERO;
    at_top = (r.count == top);
    at_bottom = (r.count == CNT_ZERO);
    wrap = 1'b0;
    ovf_set = 1'b0;
    // A loaded count of MAX must still wrap under a fixed top
    top_hit = at_top && !(top_var && r.block);

    // ****************************************************
    // Match detect
    // ****************************************************
    // full compare
    for (int u = 0; u < 2; u++) begin
      match[u] = tick && !r.block && (r.count == r.active[u]);
    end

    // ****************************************************
    // Counter
    // ****************************************************
    // A top held in a register obeys blocking as well
    if (tick) begin
      if (dual) begin
        if (!r.down) begin
          if (top_hit) begin
            next_r.down = 1'b1;
            next_r.count = r.count - CNT_ONE;
          end else begin
            next_r.count = r.count + CNT_ONE;
          end
        end else begin
          if (at_bottom) begin
            next_r.down = 1'b0;
            next_r.count = r.count + CNT_ONE;
            next_r.ovf_flag = 1'b1;
            ovf_set = 1'b1;
          end else begin
            next_r.count = r.count - CNT_ONE;
          end
        end
      end else begin
        next_r.down = 1'b0;
        if (top_hit) begin
          next_r.count = CNT_ZERO;
          wrap = 1'b1;
        end else begin
          next_r.count = r.count + CNT_ONE;
        end
        if (ovf_at_max ? (r.count == CNT_MAX) : top_hit) begin
          next_r.ovf_flag = 1'b1;
          ovf_set = 1'b1;
        end
      end
      // Blocking lasts through a stopped timer clock until the next tick
      next_r.block = 1'b0;
    end

    if (pwm && tick) begin
      // Reload only at the turning point keeps PWM pulses whole
      if (load_at_bottom ? (r.down && at_bottom) : top_hit) begin
        next_r.active = r.buffer;
      end
    end

    // ****************************************************
    // Waveform generation per unit
    // ****************************************************
    for (int u = 0; u < 2; u++) begin
      act = r.action[u];
      if (match[u]) begin
        next_r.match_flag[u] = 1'b1;
      end
      // The strobe is not stored, so it always reads back as zero
      // ignored in PWM
      if (wr && addr == OFS_FORCE && !pwm) begin
        force_hit[u] = wdata[u == 0 ? BIT_FORCE_A : BIT_FORCE_B];
      end
      if (!pwm && (match[u] || force_hit[u])) begin
        case (act)
          ACT_TOGGLE: next_r.out_reg[u] = !r.out_reg[u];
          ACT_CLEAR: next_r.out_reg[u] = 1'b0;
          ACT_SET: next_r.out_reg[u] = 1'b1;
          default: next_r.out_reg[u] = r.out_reg[u];
        endcase
      end else if (pwm && act[1]) begin
        if (match[u]) begin
          next_r.out_reg[u] = act[0] ^ r.down;
        end else if (!dual && wrap) begin
          next_r.out_reg[u] = !act[0];
        end
      end
    end

    // ****************************************************
    // Register writes
    // ****************************************************
    if (wr) begin
      case (addr)
        OFS_MODE: begin
          next_r.mode = wdata[3:0];
        end
        OFS_ACTION: begin
          next_r.action[0] = wdata[BIT_ACT_A +: 2];
          next_r.action[1] = wdata[BIT_ACT_B +: 2];
        end
        OFS_IRQ_EN: begin
          next_r.irq_en = wdata[2:0];
        end
        OFS_CNT_HI, OFS_CMPA_HI, OFS_CMPB_HI: begin
          next_r.temp = wdata;
        end
        OFS_CNT_LO: begin
          next_r.count = {r.temp, wdata};
          next_r.block = 1'b1;
        end
        OFS_CMPA_LO, OFS_CMPB_LO: begin
          // buffer or direct
          // A lone low write commits whatever the holding byte has
          wide = {r.temp, wdata};
          if (addr == OFS_CMPA_LO) begin
            next_r.buffer[0] = wide;
            if (!pwm) begin
              next_r.active[0] = wide;
            end
          end else begin
            next_r.buffer[1] = wide;
            if (!pwm) begin
              next_r.active[1] = wide;
            end
          end
        end
        default: begin
          next_r.temp = r.temp;
        end
      endcase
    end

    // ****************************************************
    // Flag clears
    // ****************************************************
    // flag clears, set wins
    if (wr && addr == OFS_FLAGS) begin
      if (wdata[BIT_OVF] && !ovf_set) begin
        next_r.ovf_flag = 1'b0;
      end
      for (int u = 0; u < 2; u++) begin
        if (wdata[BIT_CMPA + u] && !match[u]) begin
          next_r.match_flag[u] = 1'b0;
        end
      end
    end
    if (irq_serviced[BIT_OVF] && !ovf_set) begin
      next_r.ovf_flag = 1'b0;
    end
    for (int u = 0; u < 2; u++) begin
      if (irq_serviced[BIT_CMPA + u] && !match[u]) begin
        next_r.match_flag[u] = 1'b0;
      end
    end

    // ****************************************************
    // Register reads
    // ****************************************************
    next_r.rdata = BYTE_ZERO;
    if (rd) begin
      case (addr)
        OFS_MODE: next_r.rdata = {4'h0, r.mode};
        OFS_ACTION: next_r.rdata = {r.action[0], r.action[1], 4'h0};
        OFS_IRQ_EN: next_r.rdata = {5'h00, r.irq_en};
        OFS_FLAGS: next_r.rdata = {5'h00, r.match_flag, r.ovf_flag};
        OFS_CNT_LO: begin
          // Latching the high byte keeps a 16-bit count read coherent
          next_r.rdata = r.count[7:0];
          next_r.temp = r.count[15:8];
        end
        OFS_CNT_HI: next_r.rdata = r.temp;
        OFS_CMPA_LO: next_r.rdata = pwm ? r.buffer[0][7:0] : r.active[0][7:0];
        OFS_CMPA_HI: next_r.rdata = pwm ? r.buffer[0][15:8]
                                        : r.active[0][15:8];
        OFS_CMPB_LO: next_r.rdata = pwm ? r.buffer[1][7:0] : r.active[1][7:0];
        OFS_CMPB_HI: next_r.rdata = pwm ? r.buffer[1][15:8]
                                        : r.active[1][15:8];
        default: next_r.rdata = BYTE_ZERO;
      endcase
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign rdata = r.rdata;
  assign timer_count = r.count;
  assign overflow_flag = r.ovf_flag;
  assign compare_match_flag = r.match_flag;
  assign compare_output = r.out_reg;
  // interrupt requests
  // Requests follow the flags; the core's vector logic does the rest
  assign irq_request = {r.match_flag, r.ovf_flag} & r.irq_en;

  // capture untouched
  // Direction stays with the port so the pin can be staged before enable
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      pin_out[u] = (r.action[u] != ACT_NONE) ? r.out_reg[u] : port_value[u];
      pin_oe[u] = output_pin_direction[u];
    end
  end
endmodule : tocu_top
`default_nettype wire

// ---- tocu_pkg.sv ----
// Purpose: Constants and types for the timer output compare unit
// Assumes: 8-bit register port, 16-bit counter, two compare units
// Notes: Offsets are byte addresses on the plain register port
`default_nettype none
package tocu_pkg;
  // ****************************************************
  // Register offsets
  // ****************************************************
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_ACTION = 4'h1;
  localparam logic [3:0] OFS_FORCE = 4'h2;
  localparam logic [3:0] OFS_IRQ_EN = 4'h3;
  localparam logic [3:0] OFS_FLAGS = 4'h4;
  localparam logic [3:0] OFS_CNT_LO = 4'h5;
  localparam logic [3:0] OFS_CNT_HI = 4'h6;
  localparam logic [3:0] OFS_CMPA_LO = 4'h7;
  localparam logic [3:0] OFS_CMPA_HI = 4'h8;
  localparam logic [3:0] OFS_CMPB_LO = 4'h9;
  localparam logic [3:0] OFS_CMPB_HI = 4'hA;
  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int BIT_OVF = 0;
  localparam int BIT_CMPA = 1;
  localparam int BIT_CMPB = 2;
  localparam int BIT_ACT_A = 6;
  localparam int BIT_ACT_B = 4;
  localparam int BIT_FORCE_A = 7;
  localparam int BIT_FORCE_B = 6;
  // ****************************************************
  // Values
  // ****************************************************
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_CMP = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_RESERVED = 4'hD;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [15:0] count;
    logic down;
    logic [7:0] temp;
    logic [1:0][15:0] active;
    logic [1:0][15:0] buffer;
    logic [1:0] out_reg;
    logic [1:0] match_flag;
    logic ovf_flag;
    logic block;
    logic [3:0] mode;
    logic [1:0][1:0] action;
    logic [2:0] irq_en;
    logic [7:0] rdata;
  } tocu_state_t;
endpackage : tocu_pkg
`default_nettype wire

// ---- tocu_props.sv ----
// Purpose: Port checks of the timer output compare unit
// Assumes: One clock domain, synchronous active-high reset
// Notes: Mode, action and match block are shadowed from port writes
`default_nettype none
module tocu_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic [2:0] irq_serviced,
  input wire logic [2:0] irq_request,
  input wire logic [1:0] port_value,
  input wire logic [1:0] compare_output,
  input wire logic [1:0] pin_out,
  input wire logic [15:0] timer_count,
  input wire logic overflow_flag,
  input wire logic [1:0] compare_match_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  import tocu_pkg::*;
  // ****************************************************
  // Shadow state
  // ****************************************************
  logic [3:0] mode;
  logic [7:0] act;
  logic blk;
  logic cnt_wr;
  assign cnt_wr = wr && addr == OFS_CNT_LO;
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= MODE_NORMAL;
      act <= BYTE_ZERO;
      blk <= 1'b0;
    end else begin
      if (wr && addr == OFS_MODE) mode <= wdata[3:0];
      if (wr && addr == OFS_ACTION) act <= wdata;
      blk <= cnt_wr || (blk && !tick);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_cnt_wr;
    wr && addr == OFS_CNT_LO;
  endsequence
  sequence s_wrap;
    tick && mode == MODE_NORMAL && timer_count == CNT_MAX && !cnt_wr;
  endsequence
  property p_pin;
    pin_out[0] == (act[7:6] != ACT_NONE ? compare_output[0] : port_value[0])
    && pin_out[1] == (act[5:4] != ACT_NONE ? compare_output[1] : port_value[1]);
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin source wrong");
  property p_irq;
    (irq_request & ~{compare_match_flag, overflow_flag}) == 3'b000;
  endproperty
  a_irq: assert property (p_irq)
    else $error("request without flag");
  property p_svc;
    irq_serviced[1] && !tick |=> !compare_match_flag[0];
  endproperty
  a_svc: assert property (p_svc)
    else $error("serviced flag kept");
  property p_ovf_svc;
    irq_serviced[0] && !tick |=> !overflow_flag;
  endproperty
  a_ovf_svc: assert property (p_ovf_svc)
    else $error("serviced overflow kept");
  property p_hit;
    $rose(compare_match_flag[0]) |-> $past(tick);
  endproperty
  a_hit: assert property (p_hit)
    else $error("flag set without tick");
  property p_block;
    blk && tick && compare_match_flag == 2'b00 |=> compare_match_flag == 2'b00;
  endproperty
  a_block: assert property (p_block)
    else $error("match after count write");
  property p_cnt_wr;
    s_cnt_wr |=> timer_count[7:0] == $past(wdata);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr)
    else $error("count write lost");
  property p_wrap;
    s_wrap |=> timer_count == CNT_ZERO && overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap or overflow wrong");
  property p_rst;
    $fell(rst) |-> compare_output == 2'b00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("output not cleared");
  property p_keep;
    wr && addr == OFS_MODE && !tick |=> $stable(compare_output);
  endproperty
  a_keep: assert property (p_keep)
    else $error("output lost on mode change");
  property p_idle;
    act[7:6] == ACT_NONE && !(wr && addr == OFS_ACTION)
    |=> $stable(compare_output[0]);
  endproperty
  a_idle: assert property (p_idle)
    else $error("output moved with no action");
endmodule : tocu_props
`default_nettype wire

// ---- tocu_cpu.sv ----
// Purpose: CPU core model on the 8-bit register port
// Assumes: Strobes launched right after a rising edge
// Notes: Released data is inverted so a stale byte never passes
`default_nettype none
module tocu_cpu (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************
  // Bus cycles
  // ****************************************************
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
    #1;
  endtask : put
  task automatic put16(input logic [3:0] a, input logic [15:0] v);
    put(a + 4'h1, v[15:8]);
    put(a, v[7:0]);
  endtask : put16
  task automatic get(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : get
endmodule : tocu_cpu
`default_nettype wire

// ---- tocu_tb.sv ----
// Purpose: Self-checking bench of the timer output compare unit
// Assumes: Timer clock enable pulses are made here
// Notes: Count is only written in normal mode, never at a PWM top
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tocu_pkg::*;
  logic clk, rst, tick, wr, rd, overflow_flag;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [15:0] capture_value, timer_count;
  logic [2:0] irq_serviced, irq_request;
  logic [1:0] port_value, output_pin_direction, compare_output;
  logic [1:0] pin_out, pin_oe, compare_match_flag;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  tocu_top dut (
    .clk(clk), .rst(rst), .tick(tick), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .capture_value(capture_value),
    .irq_serviced(irq_serviced), .irq_request(irq_request),
    .port_value(port_value), .output_pin_direction(output_pin_direction),
    .compare_output(compare_output), .pin_out(pin_out), .pin_oe(pin_oe),
    .timer_count(timer_count), .overflow_flag(overflow_flag),
    .compare_match_flag(compare_match_flag)
  );
  tocu_cpu cpu (
    .clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd)
  );
  // ****************************************************
  // Helpers
  // ****************************************************
  task automatic chk(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic step;
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    #1;
  endtask : step
  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_force;
    cpu.put(OFS_ACTION, 8'hC0);
    cpu.put(OFS_FORCE, 8'h80);
    chk("force set", 16'h1, compare_output);
    chk("force flag", 16'h0, compare_match_flag);
    cpu.put(OFS_ACTION, 8'h80);
    cpu.put(OFS_FORCE, 8'h80);
    chk("force clear", 16'h0, compare_output);
    cpu.put(OFS_ACTION, 8'hC0);
    cpu.put(OFS_FORCE, 8'h80);
    cpu.put(OFS_MODE, 8'h05);
    chk("mode keep", 16'h1, compare_output);
    cpu.put(OFS_ACTION, 8'h80);
    cpu.put(OFS_FORCE, 8'h80);
    chk("pwm force", 16'h1, compare_output);
    cpu.get(OFS_FORCE, d);
    chk("force read", 16'h0, d);
    cpu.put(OFS_MODE, 8'h00);
    @(posedge clk);
    output_pin_direction <= 2'b01;
    port_value <= 2'b10;
    #1;
    chk("pin", 16'h3, pin_out);
    chk("oe", 16'h1, pin_oe);
  endtask : t_force
  task automatic t_match;
    cpu.put(OFS_ACTION, 8'h40);
    cpu.put(OFS_IRQ_EN, 8'h02);
    cpu.put16(OFS_CMPA_LO, 16'h1205);
    cpu.put(OFS_CMPB_HI, 8'h77);
    cpu.get(OFS_CMPA_HI, d);
    chk("cmp high", 16'h12, d);
    cpu.put16(OFS_CNT_LO, 16'h1204);
    step;
    step;
    chk("flag", 16'h1, compare_match_flag);
    chk("toggle", 16'h2, pin_out);
    chk("irq", 16'h2, irq_request);
    @(posedge clk);
    irq_serviced <= 3'b010;
    @(posedge clk);
    irq_serviced <= 3'b000;
    #1;
    chk("serviced", 16'h0, compare_match_flag);
    cpu.put16(OFS_CNT_LO, 16'h1205);
    step;
    chk("blocked", 16'h0, compare_match_flag);
    cpu.put16(OFS_CNT_LO, 16'h1204);
    step;
    step;
    chk("flag again", 16'h1, compare_match_flag);
    cpu.put(OFS_FLAGS, 8'h02);
    chk("w1c", 16'h0, compare_match_flag);
  endtask : t_match
  task automatic t_wrap;
    cpu.put16(OFS_CNT_LO, CNT_MAX);
    step;
    chk("wrap", CNT_ZERO, timer_count);
    chk("ovf", 16'h1, overflow_flag);
    @(posedge clk);
    irq_serviced <= 3'b001;
    @(posedge clk);
    irq_serviced <= 3'b000;
    #1;
    chk("ovf serviced", 16'h0, overflow_flag);
    cpu.put(OFS_CNT_HI, 8'h00);
    fork
      cpu.put(OFS_CNT_LO, 8'h10);
      step;
    join
    chk("write wins", 16'h0010, timer_count);
    cpu.get(4'hF, d);
    chk("unmapped", 16'h0, d);
  endtask : t_wrap
  task automatic t_pwm;
    cpu.put16(OFS_CNT_LO, 16'h00FE);
    cpu.put(OFS_MODE, 8'h05);
    cpu.put(OFS_ACTION, 8'h80);
    cpu.put16(OFS_CMPA_LO, 16'h0002);
    cpu.get(OFS_CMPA_LO, d);
    chk("buffer read", 16'h02, d);
    repeat (4) step;
    chk("pwm hold", 16'h1, compare_output);
    step;
    chk("pwm match", 16'h0, compare_output);
    chk("pwm count", 16'h0003, timer_count);
  endtask : t_pwm
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    rst = 1'b1;
    tick = 1'b0;
    capture_value = 16'h0000;
    irq_serviced = 3'b000;
    port_value = 2'b00;
    output_pin_direction = 2'b00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset out", 16'h0, compare_output);
    t_force();
    t_match();
    t_wrap();
    t_pwm();
    print_verdict();
  end
endmodule : testbench
bind tocu_top tocu_props u_props (
  .clk(clk), .rst(rst), .tick(tick), .addr(addr), .wdata(wdata), .wr(wr),
  .irq_serviced(irq_serviced), .irq_request(irq_request),
  .port_value(port_value), .compare_output(compare_output),
  .pin_out(pin_out), .timer_count(timer_count),
  .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag)
);
`default_nettype wire
